// ---- rtl/prio_bank.sv ----
`timescale 1ns/100ps
// APB register bank of interrupt priority fields feeding the arbiter

// Notes on behaviour
// R1 - Fields are three bits; code 111 means level 7, the highest.
// R2 - Code 001 is level 1; codes between give their binary value.
// R3 - Code 000 disables the source entirely.
// R4 - Unimplemented bits read zero and ignore writes.
// R5 - Power-on reset loads 100, level 4, into every field.
// R6 - Every field bit is readable and writable; read returns last write.
// R7 - Register 8: SPI B event bits 6-4, fault bits 2-0.
// R8 - Register 9: capture 5 at 14-12, 4 at 10-8, 3 at 6-4.
// R9 - Register 10: compare 7, 6, 5 and capture 6 in four fields.
// R10 - Register 11: parallel port bits 6-4, compare 8 bits 2-0.
// R11 - Register 12: two-wire B master 10-8, slave 6-4.
// R12 - Register 13: external pin 4 at 10-8, pin 3 at 6-4.
// R13 - Register 15: calendar level at 10-8, rest unimplemented.
// R14 - Field levels drive the arbiter continuously, effective next cycle.
module prio_bank
  import prio_bank_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  output levels_t levels,
  output logic [NUM_FIELDS-2:0] source_enabled
);

  localparam logic [ADDR_W-1:0] IDX_TABLE [NUM_REGS] = '{
    IDX_SPI_B, IDX_CAPTURE_A, IDX_COMPARE_CAPTURE, IDX_PARPORT_COMPARE,
    IDX_TWOWIRE_B, IDX_EXT_PINS_B, IDX_CALENDAR};
  localparam logic [15:0] MASK_TABLE [NUM_REGS] = '{
    MASK_SPI_B, MASK_CAPTURE_A, MASK_COMPARE_CAPTURE, MASK_PARPORT_COMPARE,
    MASK_TWOWIRE_B, MASK_EXT_PINS_B, MASK_CALENDAR};

  // Word select from a byte address; low two bits must be zero
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] idx);
    hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]);
  endfunction

  logic [15:0] word [NUM_REGS];
  logic [NUM_REGS-1:0] sel;
  logic access;
  logic any_hit;
  logic [15:0] rd_word;
  apb_rsp_t apb_rsp_r;
  apb_rsp_t apb_rsp_nxt;
  levels_t levels_r;
  levels_t levels_nxt;
  logic [NUM_FIELDS-2:0] enabled_r;
  logic [NUM_FIELDS-2:0] enabled_nxt;
  logic pending_r;

  // Access phase, answered one cycle after it starts (pready registered)
  assign access = apb_req.psel && apb_req.penable && !pending_r;

  // Register instances and their decode
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      assign sel[g] = hit(apb_req.paddr, IDX_TABLE[g]);
      prio_word #(.MASK(MASK_TABLE[g])) u_word (
        .clk(clk),
        .resetn(resetn),
        .wr_en(access && apb_req.pwrite && sel[g]), // [R6]
        .wr_data(apb_req.pwdata[15:0]),
        .value(word[g])
      );
    end
  endgenerate

  assign any_hit = |sel;

  // Read mux; upper bus bits and unmapped words read zero
  always_comb begin
    rd_word = 16'h0000;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (sel[i]) begin
        rd_word = rd_word | word[i]; // [R4]
      end
    end
  end

  assign apb_rsp_nxt.pready = access;
  assign apb_rsp_nxt.pslverr = access && !any_hit;
  assign apb_rsp_nxt.prdata = (access && !apb_req.pwrite) ? {16'h0000, rd_word} : 32'h0;

  // Field extraction from the stored words
  assign levels_nxt.spi_b_event_level = word[0][POS_6 +: FIELD_W]; // [R7]
  assign levels_nxt.spi_b_fault_level = word[0][POS_2 +: FIELD_W]; // [R7]
  assign levels_nxt.capture5_level = word[1][POS_14 +: FIELD_W]; // [R8]
  assign levels_nxt.capture4_level = word[1][POS_10 +: FIELD_W]; // [R8]
  assign levels_nxt.capture3_level = word[1][POS_6 +: FIELD_W]; // [R8]
  assign levels_nxt.compare7_level = word[2][POS_14 +: FIELD_W]; // [R9]
  assign levels_nxt.compare6_level = word[2][POS_10 +: FIELD_W]; // [R9]
  assign levels_nxt.compare5_level = word[2][POS_6 +: FIELD_W]; // [R9]
  assign levels_nxt.capture6_level = word[2][POS_2 +: FIELD_W]; // [R9]
  assign levels_nxt.parallel_port_level = word[3][POS_6 +: FIELD_W]; // [R10]
  assign levels_nxt.compare8_level = word[3][POS_2 +: FIELD_W]; // [R10]
  assign levels_nxt.twowire_b_master_level = word[4][POS_10 +: FIELD_W]; // [R11]
  assign levels_nxt.twowire_b_slave_level = word[4][POS_6 +: FIELD_W]; // [R11]
  assign levels_nxt.ext_pin4_level = word[5][POS_10 +: FIELD_W]; // [R12]
  assign levels_nxt.ext_pin3_level = word[5][POS_6 +: FIELD_W]; // [R12]
  assign levels_nxt.calendar_level = word[6][POS_10 +: FIELD_W]; // [R13]

  // Code 000 gates the source off; any other code is its level 1..7
  generate
    for (g = 0; g < NUM_FIELDS - 1; g++) begin : g_en
      assign enabled_nxt[g] = (levels_nxt[g*FIELD_W +: FIELD_W] != LEVEL_OFF); // [R3] [R1] [R2]
    end
  endgenerate

  // Output flops; levels lag the stored word by one edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      apb_rsp_r <= '0;
      pending_r <= 1'b0;
      levels_r <= {(NUM_FIELDS - 1){FIELD_RESET}}; // [R5]
      enabled_r <= '1;
    end else begin
      apb_rsp_r <= apb_rsp_nxt;
      pending_r <= access;
      levels_r <= levels_nxt; // [R14]
      enabled_r <= enabled_nxt;
    end
  end

  assign apb_rsp = apb_rsp_r;
  assign levels = levels_r;
  assign source_enabled = enabled_r;

  // Checks
  chk_write_lands: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    access && apb_req.pwrite && sel[2] |->
      ##1 word[2] == (apb_req.pwdata[15:0] & MASK_COMPARE_CAPTURE))
    else $error("priority word did not take written value");
  chk_unimpl_zero: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    apb_rsp.pready |->
      apb_rsp.prdata[31:16] == 16'h0000 && (apb_rsp.prdata[15:0] & ~16'h7777) == 16'h0000)
    else $error("unimplemented bit read as one");
  chk_ready_timing: assert property (@(posedge clk) disable iff (!resetn)
    apb_req.psel && apb_req.penable && !pending_r |-> ##1 apb_rsp.pready)
    else $error("pready late");
  chk_level_follow: assert property (@(posedge clk) disable iff (!resetn) // [R14]
    ##1 levels.capture5_level == $past(word[1][POS_14 +: FIELD_W]))
    else $error("level output did not follow field");
  chk_off_disables: assert property (@(posedge clk) disable iff (!resetn) // [R3]
    levels.calendar_level == LEVEL_OFF |-> !source_enabled[0])
    else $error("disabled source still enabled");
  chk_spi_map: assert property (@(posedge clk) disable iff (!resetn) // [R7]
    ##1 levels.spi_b_fault_level == $past(word[0][2:0]))
    else $error("fault level mapped wrong");
  chk_unmapped_err: assert property (@(posedge clk) disable iff (!resetn)
    access && !any_hit |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped address not flagged");
  chk_reset_level: assert property (@(posedge clk) // [R5]
    !resetn |=> levels.ext_pin3_level == FIELD_RESET && word[5] == 16'h0440)
    else $error("reset value wrong");
  cov_write: cover property (@(posedge clk) disable iff (!resetn) access && apb_req.pwrite && any_hit);
  cov_read: cover property (@(posedge clk) disable iff (!resetn) access && !apb_req.pwrite && any_hit);
  cov_off: cover property (@(posedge clk) disable iff (!resetn) levels.compare8_level == LEVEL_OFF);
  cov_top_level: cover property (@(posedge clk) disable iff (!resetn) levels.calendar_level == 3'h7);
  cov_back_to_back: cover property (@(posedge clk) disable iff (!resetn) access ##3 access);

  // The answer is a single-cycle pulse; a request still held after pready is taken again two cycles after its first take
  chk_ready_pulse: assert property (@(posedge clk) disable iff (!resetn)
    apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready stood longer than one cycle");

  // Each level output carries the bits its rule names, one edge behind the word
  chk_spi_event_map: assert property (@(posedge clk) disable iff (!resetn) // [R7]
    ##1 levels.spi_b_event_level == $past(word[0][6:4]))
    else $error("event level mapped wrong");
  chk_capture4_map: assert property (@(posedge clk) disable iff (!resetn) // [R8]
    ##1 levels.capture4_level == $past(word[1][10:8]))
    else $error("capture 4 level mapped wrong");
  chk_capture3_map: assert property (@(posedge clk) disable iff (!resetn) // [R8]
    ##1 levels.capture3_level == $past(word[1][6:4]))
    else $error("capture 3 level mapped wrong");
  chk_compare7_map: assert property (@(posedge clk) disable iff (!resetn) // [R9]
    ##1 levels.compare7_level == $past(word[2][14:12]))
    else $error("compare 7 level mapped wrong");
  chk_compare6_map: assert property (@(posedge clk) disable iff (!resetn) // [R9]
    ##1 levels.compare6_level == $past(word[2][10:8]))
    else $error("compare 6 level mapped wrong");
  chk_compare5_map: assert property (@(posedge clk) disable iff (!resetn) // [R9]
    ##1 levels.compare5_level == $past(word[2][6:4]))
    else $error("compare 5 level mapped wrong");
  chk_capture6_map: assert property (@(posedge clk) disable iff (!resetn) // [R9]
    ##1 levels.capture6_level == $past(word[2][2:0]))
    else $error("capture 6 level mapped wrong");
  chk_parport_map: assert property (@(posedge clk) disable iff (!resetn) // [R10]
    ##1 levels.parallel_port_level == $past(word[3][6:4]))
    else $error("parallel port level mapped wrong");
  chk_compare8_map: assert property (@(posedge clk) disable iff (!resetn) // [R10]
    ##1 levels.compare8_level == $past(word[3][2:0]))
    else $error("compare 8 level mapped wrong");
  chk_twowire_master_map: assert property (@(posedge clk) disable iff (!resetn) // [R11]
    ##1 levels.twowire_b_master_level == $past(word[4][10:8]))
    else $error("two-wire master level mapped wrong");
  chk_twowire_slave_map: assert property (@(posedge clk) disable iff (!resetn) // [R11]
    ##1 levels.twowire_b_slave_level == $past(word[4][6:4]))
    else $error("two-wire slave level mapped wrong");
  chk_pin4_map: assert property (@(posedge clk) disable iff (!resetn) // [R12]
    ##1 levels.ext_pin4_level == $past(word[5][10:8]))
    else $error("pin 4 level mapped wrong");
  chk_pin3_map: assert property (@(posedge clk) disable iff (!resetn) // [R12]
    ##1 levels.ext_pin3_level == $past(word[5][6:4]))
    else $error("pin 3 level mapped wrong");
  chk_calendar_map: assert property (@(posedge clk) disable iff (!resetn) // [R13]
    ##1 levels.calendar_level == $past(word[6][10:8]))
    else $error("calendar level mapped wrong");

  // Writes land at the access edge; the master still holds its data one edge later
  chk_write_spi: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    access && apb_req.pwrite && sel[0] |=>
      word[0] == (apb_req.pwdata[15:0] & MASK_SPI_B))
    else $error("spi word did not take written value");
  chk_write_capture: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    access && apb_req.pwrite && sel[1] |=>
      word[1] == (apb_req.pwdata[15:0] & MASK_CAPTURE_A))
    else $error("capture word did not take written value");
  chk_write_parport: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    access && apb_req.pwrite && sel[3] |=>
      word[3] == (apb_req.pwdata[15:0] & MASK_PARPORT_COMPARE))
    else $error("parallel port word did not take written value");
  chk_write_twowire: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    access && apb_req.pwrite && sel[4] |=>
      word[4] == (apb_req.pwdata[15:0] & MASK_TWOWIRE_B))
    else $error("two-wire word did not take written value");
  chk_write_pins: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    access && apb_req.pwrite && sel[5] |=>
      word[5] == (apb_req.pwdata[15:0] & MASK_EXT_PINS_B))
    else $error("pin word did not take written value");
  chk_write_calendar: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    access && apb_req.pwrite && sel[6] |=>
      word[6] == (apb_req.pwdata[15:0] & MASK_CALENDAR))
    else $error("calendar word did not take written value");

  // A read answers with the word as it stood at the access edge
  chk_read_spi: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    access && !apb_req.pwrite && sel[0] |=> apb_rsp.prdata == {16'h0000, $past(word[0])})
    else $error("spi word read back wrong");
  chk_read_capture: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    access && !apb_req.pwrite && sel[1] |=> apb_rsp.prdata == {16'h0000, $past(word[1])})
    else $error("capture word read back wrong");
  chk_read_compare: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    access && !apb_req.pwrite && sel[2] |=> apb_rsp.prdata == {16'h0000, $past(word[2])})
    else $error("compare word read back wrong");
  chk_read_parport: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    access && !apb_req.pwrite && sel[3] |=> apb_rsp.prdata == {16'h0000, $past(word[3])})
    else $error("parallel port word read back wrong");
  chk_read_twowire: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    access && !apb_req.pwrite && sel[4] |=> apb_rsp.prdata == {16'h0000, $past(word[4])})
    else $error("two-wire word read back wrong");
  chk_read_pins: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    access && !apb_req.pwrite && sel[5] |=> apb_rsp.prdata == {16'h0000, $past(word[5])})
    else $error("pin word read back wrong");
  chk_read_calendar: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    access && !apb_req.pwrite && sel[6] |=> apb_rsp.prdata == {16'h0000, $past(word[6])})
    else $error("calendar word read back wrong");

  // Spare bit positions never hold a one, whatever software wrote
  chk_spare_spi: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    (word[0] & ~MASK_SPI_B) == 16'h0000)
    else $error("spare spi bit set");
  chk_spare_capture: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    (word[1] & ~MASK_CAPTURE_A) == 16'h0000)
    else $error("spare capture bit set");
  chk_spare_compare: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    (word[2] & ~MASK_COMPARE_CAPTURE) == 16'h0000)
    else $error("spare compare bit set");
  chk_spare_parport: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    (word[3] & ~MASK_PARPORT_COMPARE) == 16'h0000)
    else $error("spare parallel port bit set");
  chk_spare_twowire: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    (word[4] & ~MASK_TWOWIRE_B) == 16'h0000)
    else $error("spare two-wire bit set");
  chk_spare_pins: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    (word[5] & ~MASK_EXT_PINS_B) == 16'h0000)
    else $error("spare pin bit set");
  chk_spare_calendar: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    (word[6] & ~MASK_CALENDAR) == 16'h0000)
    else $error("spare calendar bit set");

  // Reset leaves 100 in every implemented field and zero elsewhere
  chk_reset_spi: assert property (@(posedge clk) // [R5]
    !resetn |=> word[0] == 16'h0044)
    else $error("spi reset value wrong");
  chk_reset_capture: assert property (@(posedge clk) // [R5]
    !resetn |=> word[1] == 16'h4440)
    else $error("capture reset value wrong");
  chk_reset_compare: assert property (@(posedge clk) // [R5]
    !resetn |=> word[2] == 16'h4444)
    else $error("compare reset value wrong");
  chk_reset_parport: assert property (@(posedge clk) // [R5]
    !resetn |=> word[3] == 16'h0044)
    else $error("parallel port reset value wrong");
  chk_reset_twowire: assert property (@(posedge clk) // [R5]
    !resetn |=> word[4] == 16'h0440)
    else $error("two-wire reset value wrong");
  chk_reset_calendar: assert property (@(posedge clk) // [R5]
    !resetn |=> word[6] == 16'h0400)
    else $error("calendar reset value wrong");

endmodule

// ---- rtl/prio_bank_pkg.sv ----
// Package with register map, field layout and reset values of the priority bank
package prio_bank_pkg;

  localparam int ADDR_W = 12;
  localparam int FIELD_W = 3;
  localparam int NUM_REGS = 7;
  localparam int NUM_FIELDS = 17;

  // Register indices as printed (8..13, 15); byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_SPI_B = 12'h008;
  localparam logic [ADDR_W-1:0] IDX_CAPTURE_A = 12'h009;
  localparam logic [ADDR_W-1:0] IDX_COMPARE_CAPTURE = 12'h00A;
  localparam logic [ADDR_W-1:0] IDX_PARPORT_COMPARE = 12'h00B;
  localparam logic [ADDR_W-1:0] IDX_TWOWIRE_B = 12'h00C;
  localparam logic [ADDR_W-1:0] IDX_EXT_PINS_B = 12'h00D;
  localparam logic [ADDR_W-1:0] IDX_CALENDAR = 12'h00F;

  // Implemented-bit masks, one per register
  localparam logic [15:0] MASK_SPI_B = 16'h0077;
  localparam logic [15:0] MASK_CAPTURE_A = 16'h7770;
  localparam logic [15:0] MASK_COMPARE_CAPTURE = 16'h7777;
  localparam logic [15:0] MASK_PARPORT_COMPARE = 16'h0077;
  localparam logic [15:0] MASK_TWOWIRE_B = 16'h0770;
  localparam logic [15:0] MASK_EXT_PINS_B = 16'h0770;
  localparam logic [15:0] MASK_CALENDAR = 16'h0700;

  // Every implemented field powers up as 100, level 4
  localparam logic [FIELD_W-1:0] FIELD_RESET = 3'h4;
  localparam logic [15:0] NIBBLE_RESET = 16'h4444;
  localparam logic [FIELD_W-1:0] LEVEL_OFF = 3'h0;

  // Field low-bit positions
  localparam int POS_14 = 12;
  localparam int POS_10 = 8;
  localparam int POS_6 = 4;
  localparam int POS_2 = 0;

  typedef struct packed {
    logic [FIELD_W-1:0] spi_b_event_level;
    logic [FIELD_W-1:0] spi_b_fault_level;
    logic [FIELD_W-1:0] capture5_level;
    logic [FIELD_W-1:0] capture4_level;
    logic [FIELD_W-1:0] capture3_level;
    logic [FIELD_W-1:0] compare7_level;
    logic [FIELD_W-1:0] compare6_level;
    logic [FIELD_W-1:0] compare5_level;
    logic [FIELD_W-1:0] capture6_level;
    logic [FIELD_W-1:0] parallel_port_level;
    logic [FIELD_W-1:0] compare8_level;
    logic [FIELD_W-1:0] twowire_b_master_level;
    logic [FIELD_W-1:0] twowire_b_slave_level;
    logic [FIELD_W-1:0] ext_pin4_level;
    logic [FIELD_W-1:0] ext_pin3_level;
    logic [FIELD_W-1:0] calendar_level;
  } levels_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

endpackage

// ---- rtl/prio_word.sv ----
`timescale 1ns/100ps
// One 16-bit priority register holding only its implemented bits
module prio_word
  import prio_bank_pkg::*;
#(
  parameter logic [15:0] MASK = 16'h0000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] value
);

  logic [15:0] value_r;
  logic [15:0] value_nxt;

  // Unimplemented bits are masked off so writes never reach them
  assign value_nxt = wr_en ? (wr_data & MASK) : value_r; // [R4] [R6]

  // Reset loads 100 into every implemented field
  always_ff @(posedge clk) begin
    if (!resetn) begin
      value_r <= NIBBLE_RESET & MASK; // [R5]
    end else begin
      value_r <= value_nxt;
    end
  end

  assign value = value_r;

endmodule

// ---- test/prio_bank_tb_top.sv ----
`timescale 1ns/100ps
// Self-checking bench for the interrupt priority register bank
module prio_bank_tb_top;
  import prio_bank_pkg::*;
  typedef struct packed {logic rd; logic err; logic [31:0] data;} note_t;
  logic clk;
  logic resetn;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  levels_t levels;
  logic [15:0] source_enabled;
  note_t notes[$];
  note_t cur;
  int err_total;
  int checks_done;
  logic [ADDR_W-1:0] idx_tab [7];
  logic [15:0] mask_tab [7];
  logic [15:0] model_w [7];
  // Register and low bit of each level field, first packed field first
  int fld_reg [16] = '{0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 4, 4, 5, 5, 6};
  int fld_pos [16] = '{4, 0, 12, 8, 4, 12, 8, 4, 0, 4, 0, 8, 4, 8, 4, 8};

  prio_bank u_prio_bank (.clk(clk), .resetn(resetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .levels(levels), .source_enabled(source_enabled));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out();
    if (err_total == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request held until pready; left up so the next setup may follow at once
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                     input note_t nt);
    int n;
    n = 0;
    notes.push_back(nt);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= a;
    apb_req.pwdata <= wd;
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (apb_rsp.pready !== 1'b1) begin
      err_total++;
      close_out();
    end
  endtask

  task automatic idle();
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr_reg(input int r, input logic [31:0] d);
    model_w[r] = d[15:0] & mask_tab[r];
    apb(1'b1, {idx_tab[r][ADDR_W-3:0], 2'b00}, d, note_t'{1'b0, 1'b0, 32'h0});
  endtask

  task automatic rd_reg(input int r);
    apb(1'b0, {idx_tab[r][ADDR_W-3:0], 2'b00}, 32'h0, note_t'{1'b1, 1'b0, {16'h0, model_w[r]}});
  endtask

  // Levels lag the stored word, so let the write settle before looking
  task automatic check_levels();
    logic [47:0] el;
    logic [15:0] ee;
    idle();
    repeat (2) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      el[47-3*i -: 3] = model_w[fld_reg[i]][fld_pos[i] +: 3];
      ee[15-i] = (el[47-3*i -: 3] != 3'h0);
    end
    chk("levels", levels, el);
    chk("source_enabled", {32'h0, source_enabled}, {32'h0, ee});
  endtask

  // Response watcher: each pready retires the oldest note
  always @(posedge clk) begin
    if (resetn === 1'b1 && apb_rsp.pready === 1'b1) begin
      if (notes.size() == 0) begin
        chk("pready", 48'h1, 48'h0);
      end else begin
        cur = notes.pop_front();
        chk("pslverr", {47'h0, apb_rsp.pslverr}, {47'h0, cur.err});
        if (cur.rd) begin
          chk("prdata", {16'h0, apb_rsp.prdata}, {16'h0, cur.data});
        end
      end
    end
  end

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    for (int r = 0; r < 7; r++) model_w[r] = NIBBLE_RESET & mask_tab[r];
  endtask

  initial begin
    void'($urandom(88));
    idx_tab = '{IDX_SPI_B, IDX_CAPTURE_A, IDX_COMPARE_CAPTURE, IDX_PARPORT_COMPARE,
                IDX_TWOWIRE_B, IDX_EXT_PINS_B, IDX_CALENDAR};
    mask_tab = '{MASK_SPI_B, MASK_CAPTURE_A, MASK_COMPARE_CAPTURE, MASK_PARPORT_COMPARE,
                 MASK_TWOWIRE_B, MASK_EXT_PINS_B, MASK_CALENDAR};
    err_total = 0;
    checks_done = 0;
    resetn = 1'b0;
    apb_req = '0;
    do_reset();
    check_levels();
    for (int r = 0; r < 7; r++) rd_reg(r);
    // Random words with junk in unimplemented and upper bits, back to back
    for (int k = 0; k < 4; k++) begin
      for (int r = 0; r < 7; r++) begin
        wr_reg(r, $urandom());
        rd_reg(r);
      end
      check_levels();
    end
    // Every code on the calendar field
    for (int c = 0; c < 8; c++) begin
      wr_reg(6, {20'hFFFFF, 1'b1, c[2:0], 8'hFF});
      rd_reg(6);
      check_levels();
    end
    // Unmapped and unaligned places refuse and leave the bank alone
    apb(1'b1, 12'h038, 32'hFFFFFFFF, note_t'{1'b0, 1'b1, 32'h0});
    apb(1'b0, 12'h038, 32'h0, note_t'{1'b1, 1'b1, 32'h0});
    apb(1'b1, 12'h021, 32'h0, note_t'{1'b0, 1'b1, 32'h0});
    apb(1'b0, 12'h100, 32'h0, note_t'{1'b1, 1'b1, 32'h0});
    rd_reg(0);
    check_levels();
    // Second reset in mid-run restores level 4 everywhere
    do_reset();
    check_levels();
    for (int r = 0; r < 7; r++) rd_reg(r);
    idle();
    close_out();
  end
endmodule
